// [design/sbc_defs.svh]
// Constants of the standby controller: register offset, field layout,
// reset value, settle counts and wake-up waits.
// Assumes inclusion by bare name from the package and the modules.
`ifndef SBC_DEFS_SVH
`define SBC_DEFS_SVH

// ----------------------------------------------------------------------
// Settle select register
// ----------------------------------------------------------------------
`define SBC_OSC_SETTLE_ADDR 16'hfffa
`define SBC_OSC_SETTLE_RST 8'h04
`define SBC_SEL_LSB 0
`define SBC_SEL_MSB 2
`define SBC_SEL_2P12 3'h0
`define SBC_SEL_2P15 3'h2
`define SBC_SEL_2P17 3'h4

// ----------------------------------------------------------------------
// Timing, in main oscillator periods and processor clocks
// ----------------------------------------------------------------------
`define SBC_SETTLE_CNT_2P12 4096
`define SBC_SETTLE_CNT_2P15 32768
`define SBC_SETTLE_CNT_2P17 131072
`define SBC_SETTLE_CNT_W 18
`define SBC_WAKE_VEC_CLK 4'h9
`define SBC_WAKE_RES_CLK 4'h1
`define SBC_WAKE_CNT_W 4

`endif

// [design/sbc_pkg.sv]
// Types of the standby controller: state encoding and state record.
// Assumes sbc_defs.svh is on the include path.
`include "sbc_defs.svh"

package sbc_pkg;

  // ----------------------------------------------------------------------
  // Standby sequencer states, one-hot
  // ----------------------------------------------------------------------
  typedef enum logic [4:0] {
    st_run = 5'b00001,
    st_halt = 5'b00010,
    st_stop = 5'b00100,
    st_settle = 5'b01000,
    st_wake = 5'b10000
  } sbc_state_type;

  // ----------------------------------------------------------------------
  // Whole state of the controller
  // ----------------------------------------------------------------------
  typedef struct packed {
    sbc_state_type st;
    logic [`SBC_SEL_MSB:`SBC_SEL_LSB] settle_sel;
    logic reset_wait;
    logic vec_after;
    logic [`SBC_WAKE_CNT_W-1:0] wake_cnt;
    logic ack_hold;
    logic cpu_clk_en;
    logic osc_enable;
    logic standby_hold;
    logic wake_vector;
    logic wake_resume;
    logic settle_start;
    logic [7:0] rdata;
  } sbc_ctrl_state_type;

endpackage : sbc_pkg

// [design/sbc_settle_timer.sv]
// Oscillator settle down-counter of the standby controller.
// Assumes count_en is high only while the oscillator really oscillates.
`timescale 1ns/1ps
`include "sbc_defs.svh"

module sbc_settle_timer #(
  parameter int CNT_W = `SBC_SETTLE_CNT_W
) (
  // Clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // Control
  input wire logic load,
  input wire logic [CNT_W-1:0] load_value,
  input wire logic count_en,
  // Status
  output logic done
);

  typedef struct packed {
    logic [CNT_W-1:0] cnt;
    logic busy;
    logic done;
  } sbc_timer_state_type;

  sbc_timer_state_type state_reg;
  sbc_timer_state_type state_next;

  // ----------------------------------------------------------------------
  // Counting
  // ----------------------------------------------------------------------
  // Counts only enabled periods, so start-up time is never included
  always_comb
  begin
    state_next = state_reg;
    state_next.done = 1'b0;
    if (load)
    begin
      state_next.cnt = load_value;
      state_next.busy = 1'b1;
    end
    else if (state_reg.busy && count_en)
    begin
      if (state_reg.cnt <= CNT_W'(1))
      begin
        state_next.cnt = '0;
        state_next.busy = 1'b0;
        state_next.done = 1'b1;
      end
      else
      begin
        state_next.cnt = state_reg.cnt - CNT_W'(1);
      end
    end
  end

  // State register
  always_ff @(posedge clk)
  begin
    if (sys_rst)
      state_reg <= '0;
    else
      state_reg <= state_next;
  end

  assign done = state_reg.done;

endmodule : sbc_settle_timer

// [design/sbc_standby_ctrl.sv]
// Standby controller: halt and stop sequencing, oscillator settle wait,
// wake-up decision and interrupt acknowledge hold-off.
// Assumes the core pulses halt_exec/stop_exec for one clock per
// instruction and the interrupt logic supplies flag and mask vectors.
`timescale 1ns/1ps
`include "sbc_defs.svh"

module sbc_standby_ctrl #(
  parameter int IRQ_N = 16,
  parameter int CNT_W = `SBC_SETTLE_CNT_W,
  parameter int SETTLE_CNT_2P12 = `SBC_SETTLE_CNT_2P12,
  parameter int SETTLE_CNT_2P15 = `SBC_SETTLE_CNT_2P15,
  parameter int SETTLE_CNT_2P17 = `SBC_SETTLE_CNT_2P17
) (
  // Clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // Processor core
  input wire logic halt_exec,
  input wire logic stop_exec,
  input wire logic flag_instr_decode,
  input wire logic flag_instr_done,
  // Interrupt logic
  input wire logic [IRQ_N-1:0] request_flags,
  input wire logic [IRQ_N-1:0] mask_flags,
  input wire logic global_irq_enable,
  input wire logic nmi_req,
  // Oscillator
  input wire logic osc_running,
  // Register port
  input wire logic [15:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  // Outputs to core, oscillator and peripherals
  output logic cpu_clk_en,
  output logic osc_enable,
  output logic standby_hold,
  output logic wake_vector,
  output logic wake_resume,
  output logic irq_ack_hold,
  output logic [7:0] reg_rdata
);

  // ----------------------------------------------------------------------
  // Reset value of the whole state
  // ----------------------------------------------------------------------
  // Reset behaves like a stop release: oscillator on, fixed 2^15 wait
  // Reset byte cut to the stored field; bits 7..3 are never stored
  localparam logic [7:0] SEL_RST_BYTE = `SBC_OSC_SETTLE_RST;
  localparam sbc_pkg::sbc_ctrl_state_type RESET_STATE = '{
    st: sbc_pkg::st_settle,
    settle_sel: SEL_RST_BYTE[`SBC_SEL_MSB:`SBC_SEL_LSB],
    reset_wait: 1'b1,
    vec_after: 1'b0,
    wake_cnt: '0,
    ack_hold: 1'b0,
    cpu_clk_en: 1'b0,
    osc_enable: 1'b1,
    standby_hold: 1'b1,
    wake_vector: 1'b0,
    wake_resume: 1'b0,
    settle_start: 1'b1,
    rdata: 8'h00
  };

  sbc_pkg::sbc_ctrl_state_type state_reg;
  sbc_pkg::sbc_ctrl_state_type state_next;
  logic [CNT_W-1:0] settle_load;
  logic settle_done;
  logic reg_hit;

  // ----------------------------------------------------------------------
  // Decoding helpers
  // ----------------------------------------------------------------------
  // Settle code to oscillator period count
  function automatic logic [CNT_W-1:0] sel_to_count(
    input logic [`SBC_SEL_MSB:`SBC_SEL_LSB] sel
  );
    logic [CNT_W-1:0] cnt;
    cnt = CNT_W'(SETTLE_CNT_2P17);
    case (sel)
      `SBC_SEL_2P12: cnt = CNT_W'(SETTLE_CNT_2P12);
      `SBC_SEL_2P15: cnt = CNT_W'(SETTLE_CNT_2P15);
      `SBC_SEL_2P17: cnt = CNT_W'(SETTLE_CNT_2P17);
      // Prohibited codes take the longest wait, the safe side
      default: cnt = CNT_W'(SETTLE_CNT_2P17);
    endcase
    return cnt;
  endfunction : sel_to_count

  // Any request whose mask is clear; masked ones never wake
  function automatic logic unmasked_pending(
    input logic [IRQ_N-1:0] req,
    input logic [IRQ_N-1:0] mask
  );
    return |(req & ~mask);
  endfunction : unmasked_pending

  // Register address match
  assign reg_hit = (reg_addr == `SBC_OSC_SETTLE_ADDR);

  // Wait after reset ignores the register code
  assign settle_load = state_reg.reset_wait ? CNT_W'(SETTLE_CNT_2P15)
                                            : sel_to_count(state_reg.settle_sel);

  // ----------------------------------------------------------------------
  // Oscillator settle timer
  // ----------------------------------------------------------------------
  // Enable tied to oscillation, so start-up delay is not counted
  // Load follows entry by one cycle, through settle_start
  sbc_settle_timer #(
    .CNT_W(CNT_W)
  ) u_settle_timer (
    .clk(clk),
    .sys_rst(sys_rst),
    .load(state_reg.settle_start),
    .load_value(settle_load),
    .count_en(osc_running),
    .done(settle_done)
  );

  // ----------------------------------------------------------------------
  // Next-state logic
  // ----------------------------------------------------------------------
  always_comb
  begin
    state_next = state_reg;
    state_next.wake_vector = 1'b0;
    state_next.wake_resume = 1'b0;
    state_next.settle_start = 1'b0;

    // Read data, registered; upper bits always zero
    state_next.rdata = 8'h00;
    if (reg_rd && reg_hit)
    begin
      state_next.rdata = {5'h00, state_reg.settle_sel};
    end

    // A read in the same cycle still returns the old code
    // Whole-byte write; only the code field is stored
    if (reg_wr && reg_hit)
    begin
      state_next.settle_sel = reg_wdata[`SBC_SEL_MSB:`SBC_SEL_LSB];
    end

    // Acknowledge hold-off; a new decode wins over a done
    if (flag_instr_decode)
    begin
      state_next.ack_hold = 1'b1;
    end
    else if (flag_instr_done)
    begin
      state_next.ack_hold = 1'b0;
    end

    case (state_reg.st)
      sbc_pkg::st_run:
      begin
        // Stop wins if the core flags both in one cycle
        if (stop_exec)
        begin
          // Peripherals are expected idle already
          state_next.st = sbc_pkg::st_stop;
          state_next.cpu_clk_en = 1'b0;
          state_next.osc_enable = 1'b0;
          state_next.standby_hold = 1'b1;
        end
        else if (halt_exec)
        begin
          state_next.st = sbc_pkg::st_halt;
          state_next.cpu_clk_en = 1'b0;
          state_next.osc_enable = 1'b1;
          state_next.standby_hold = 1'b1;
        end
      end

      sbc_pkg::st_halt:
      begin
        // A request already pending wakes on the first halt cycle
        // NMI is tested first, so it always vectors
        if (nmi_req)
        begin
          state_next.st = sbc_pkg::st_wake;
          state_next.vec_after = 1'b1;
          state_next.wake_cnt = `SBC_WAKE_VEC_CLK;
        end
        else if (unmasked_pending(request_flags, mask_flags))
        begin
          state_next.st = sbc_pkg::st_wake;
          state_next.vec_after = global_irq_enable;
          state_next.wake_cnt = global_irq_enable ? `SBC_WAKE_VEC_CLK
                                                  : `SBC_WAKE_RES_CLK;
        end
      end

      sbc_pkg::st_stop:
      begin
        // Only an unmasked request ends stop; reset acts via sys_rst
        if (unmasked_pending(request_flags, mask_flags))
        begin
          state_next.st = sbc_pkg::st_settle;
          state_next.osc_enable = 1'b1;
          state_next.settle_start = 1'b1;
          state_next.reset_wait = 1'b0;
          state_next.vec_after = global_irq_enable;
        end
      end

      sbc_pkg::st_settle:
      begin
        // Core stays frozen until the oscillator is trusted
        if (settle_done)
        begin
          state_next.st = sbc_pkg::st_run;
          state_next.cpu_clk_en = 1'b1;
          state_next.standby_hold = 1'b0;
          state_next.reset_wait = 1'b0;
          // After reset no pulse: the core starts at its reset vector
          if (!state_reg.reset_wait)
          begin
            state_next.wake_vector = state_reg.vec_after;
            state_next.wake_resume = !state_reg.vec_after;
          end
        end
      end

      sbc_pkg::st_wake:
      begin
        // Fixed restart delay before the core clock returns
        // One step per clock; a count of one ends on this edge
        if (state_reg.wake_cnt <= `SBC_WAKE_RES_CLK)
        begin
          state_next.st = sbc_pkg::st_run;
          state_next.cpu_clk_en = 1'b1;
          state_next.standby_hold = 1'b0;
          state_next.wake_cnt = '0;
          state_next.wake_vector = state_reg.vec_after;
          state_next.wake_resume = !state_reg.vec_after;
        end
        else
        begin
          state_next.wake_cnt = state_reg.wake_cnt - `SBC_WAKE_RES_CLK;
        end
      end

      // Lost state recovers to run instead of freezing the core
      default:
      begin
        state_next.st = sbc_pkg::st_run;
        state_next.cpu_clk_en = 1'b1;
        state_next.osc_enable = 1'b1;
        state_next.standby_hold = 1'b0;
      end
    endcase
  end

  // ----------------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------------
  // Reset from any state restarts at the reset vector after settling
  // Synchronous reset only; sys_rst is taken as clean to clk
  always_ff @(posedge clk)
  begin
    if (sys_rst)
      state_reg <= RESET_STATE;
    else
      state_reg <= state_next;
  end

  // ----------------------------------------------------------------------
  // Outputs, all straight from the state register
  // ----------------------------------------------------------------------
  // No output passes through logic, so none can glitch at the core
  assign cpu_clk_en = state_reg.cpu_clk_en;
  assign osc_enable = state_reg.osc_enable;
  assign standby_hold = state_reg.standby_hold;
  assign wake_vector = state_reg.wake_vector;
  assign wake_resume = state_reg.wake_resume;
  assign irq_ack_hold = state_reg.ack_hold;
  assign reg_rdata = state_reg.rdata;

endmodule : sbc_standby_ctrl

// [verif/sbc_ctrl_props.sv]
// Port checker of the standby controller.
// Assumes a bind onto sbc_standby_ctrl with the same IRQ_N.
`timescale 1ns/1ps
module sbc_ctrl_props #(
  parameter int IRQ_N = 16
) (
  // Clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // Core, interrupts, register port
  input wire logic halt_exec,
  input wire logic stop_exec,
  input wire logic flag_instr_decode,
  input wire logic [IRQ_N-1:0] request_flags,
  input wire logic [IRQ_N-1:0] mask_flags,
  input wire logic global_irq_enable,
  input wire logic nmi_req,
  input wire logic [15:0] reg_addr,
  input wire logic reg_rd,
  // Outputs
  input wire logic cpu_clk_en,
  input wire logic osc_enable,
  input wire logic standby_hold,
  input wire logic wake_vector,
  input wire logic wake_resume,
  input wire logic irq_ack_hold,
  input wire logic [7:0] reg_rdata
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (sys_rst);
  logic in_halt_reg;
  logic in_stop_reg;
  logic unmasked;
  // Waking request; halt and stop tracked until their release edge
  assign unmasked = |(request_flags & ~mask_flags);
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      in_halt_reg <= 1'b0;
      in_stop_reg <= 1'b0;
    end
    else
    begin
      in_halt_reg <= cpu_clk_en ? halt_exec & ~stop_exec : in_halt_reg & ~unmasked & ~nmi_req;
      in_stop_reg <= cpu_clk_en ? stop_exec : in_stop_reg & ~unmasked;
    end
  end
  // Wake-up walks, counted from the release edge
  sequence s_resume;
    !cpu_clk_en ##1 cpu_clk_en && wake_resume;
  endsequence
  sequence s_vector;
    !cpu_clk_en [*8] ##1 !cpu_clk_en ##1 cpu_clk_en && wake_vector;
  endsequence
  property p_hold_set;
    flag_instr_decode |=> irq_ack_hold;
  endproperty
  a_hold_set: assert property (p_hold_set) else $error("hold-off not raised");
  property p_halt_in;
    cpu_clk_en && halt_exec && !stop_exec |=> !cpu_clk_en && osc_enable && standby_hold;
  endproperty
  a_halt_in: assert property (p_halt_in) else $error("bad halt entry");
  property p_stop_in;
    cpu_clk_en && stop_exec |=> !cpu_clk_en && !osc_enable && standby_hold;
  endproperty
  a_stop_in: assert property (p_stop_in) else $error("bad stop entry");
  property p_halt_keep;
    in_halt_reg && !unmasked && !nmi_req |=> !cpu_clk_en && standby_hold;
  endproperty
  a_halt_keep: assert property (p_halt_keep) else $error("halt left");
  property p_halt_res;
    in_halt_reg && unmasked && !nmi_req && !global_irq_enable |=> s_resume;
  endproperty
  a_halt_res: assert property (p_halt_res) else $error("bad resume");
  property p_halt_vec;
    in_halt_reg && (nmi_req || unmasked && global_irq_enable) |=> s_vector;
  endproperty
  a_halt_vec: assert property (p_halt_vec) else $error("bad vector");
  property p_stop_keep;
    in_stop_reg && !unmasked |=> !osc_enable;
  endproperty
  a_stop_keep: assert property (p_stop_keep) else $error("stop left");
  property p_stop_wake;
    in_stop_reg && unmasked |=> osc_enable && !cpu_clk_en;
  endproperty
  a_stop_wake: assert property (p_stop_wake) else $error("bad stop wake");
  property p_rd_unmap;
    reg_rd && reg_addr != 16'hfffa |=> reg_rdata == 8'h00;
  endproperty
  a_rd_unmap: assert property (p_rd_unmap) else $error("unmapped read");
endmodule : sbc_ctrl_props

bind sbc_standby_ctrl sbc_ctrl_props #(.IRQ_N(IRQ_N)) sbc_ctrl_props_inst (
  .clk, .sys_rst, .halt_exec, .stop_exec, .flag_instr_decode, .request_flags,
  .mask_flags, .global_irq_enable, .nmi_req, .reg_addr, .reg_rd, .cpu_clk_en,
  .osc_enable, .standby_hold, .wake_vector, .wake_resume, .irq_ack_hold, .reg_rdata
);

// [verif/sbc_osc_model.sv]
// Main oscillator model at the far side of the controller.
// Assumes clk stands in for the oscillator output.
`timescale 1ns/1ps
module sbc_osc_model #(
  parameter int START_DLY = 6
) (
  // Clock
  input wire logic clk,
  // Oscillator control
  input wire logic osc_enable,
  output logic osc_running
);
  int start_cnt;
  // Start-up gap, which the settle count must skip
  always_ff @(posedge clk)
  begin
    if (osc_enable !== 1'b1)
      start_cnt <= 0;
    else if (start_cnt < START_DLY)
      start_cnt <= start_cnt + 1;
  end
  // Stops at once when disabled
  assign osc_running = (osc_enable === 1'b1) && (start_cnt == START_DLY);
endmodule : sbc_osc_model

// [verif/test_standby_halt_stop_control.sv]
// Bench of the standby controller: reset, register, stop, halt, hold-off.
// Assumes the controller, checker and oscillator model compile first.
`timescale 1ns/1ps
module test_standby_halt_stop_control;
  localparam int C12 = 8;
  localparam int C15 = 16;
  localparam int C17 = 32;
  logic clk, sys_rst, halt_exec, stop_exec, flag_instr_decode, flag_instr_done;
  logic global_irq_enable, nmi_req, osc_running, reg_wr, reg_rd, ie;
  logic cpu_clk_en, osc_enable, standby_hold, wake_vector, wake_resume, irq_ack_hold;
  logic [15:0] request_flags, mask_flags, reg_addr;
  logic [7:0] reg_wdata, reg_rdata, d;
  logic [2:0] code;
  logic [1:0] wk;
  int fails, n_tests, n;

  sbc_standby_ctrl #(
    .SETTLE_CNT_2P12(C12),
    .SETTLE_CNT_2P15(C15),
    .SETTLE_CNT_2P17(C17)
  ) sbc_standby_ctrl_inst (
    .clk, .sys_rst, .halt_exec, .stop_exec, .flag_instr_decode, .flag_instr_done,
    .request_flags, .mask_flags, .global_irq_enable, .nmi_req, .osc_running,
    .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .cpu_clk_en, .osc_enable,
    .standby_hold, .wake_vector, .wake_resume, .irq_ack_hold, .reg_rdata
  );
  sbc_osc_model sbc_osc_model_inst (.clk, .osc_enable, .osc_running);

  // 100 MHz clock
  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // Settle count of a code; prohibited codes take the longest
  function automatic int settle_of(input logic [2:0] c);
    return (c == 3'h0) ? C12 : (c == 3'h2) ? C15 : C17;
  endfunction : settle_of

  // Tolerate up to two cycles of registered latency
  function automatic int fit(input int got, input int e);
    return (got >= e && got <= e + 2) ? e : got;
  endfunction : fit

  task automatic chk(input string what, input logic [31:0] e, input logic [31:0] g);
    n_tests++;
    if (g !== e)
    begin
      $display("[ERR] %s expected %0h seen %0h", what, e, g);
      fails++;
    end
  endtask : chk

  task automatic stop_test;
    $display("checks %0d mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : stop_test

  task automatic wreg(input logic [15:0] a, input logic [7:0] v);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= v;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask : wreg

  // Read data stands for one cycle only
  task automatic rreg(input logic [15:0] a);
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1;
    d = reg_rdata;
  endtask : rreg

  // Count oscillating cycles until the core clock returns
  task automatic wait_run;
    n = 0;
    for (int i = 0; i < 300; i++)
    begin
      @(posedge clk);
      #1;
      if (cpu_clk_en === 1'b1)
      begin
        wk = {wake_vector, wake_resume};
        return;
      end
      if (osc_running === 1'b1)
        n++;
    end
    fails++;
    stop_test();
  endtask : wait_run

  // Main sequence
  initial
  begin
    {halt_exec, stop_exec, flag_instr_decode, flag_instr_done, nmi_req} = 5'h00;
    {reg_wr, reg_rd, global_irq_enable, sys_rst} = 4'h1;
    {request_flags, mask_flags, reg_addr, reg_wdata} = {16'h0000, 16'hffff, 16'h0000, 8'h00};
    fails = 0;
    n_tests = 0;
    void'($urandom(76654));
    repeat (20) @(posedge clk);
    sys_rst <= 1'b0;
    wait_run();
    chk("rst wait", C15, fit(n, C15));
    wreg(16'hfff9, 8'h02);
    rreg(16'hfffa);
    chk("sel rst", 8'h04, d);
    rreg(16'hfff9);
    chk("unmapped", 8'h00, d);
    // Stop with each of the three legal codes and one prohibited
    for (int k = 0; k < 4; k++)
    begin
      code = 3'(2 * k);
      if (k == 3)
        code = 3'($urandom % 2 ? 1 + 2 * ($urandom % 3) : 7);
      ie = 1'($urandom);
      wreg(16'hfffa, {5'($urandom), code});
      rreg(16'hfffa);
      chk("sel", {5'h00, code}, d);
      @(posedge clk);
      request_flags <= 16'($urandom);
      stop_exec <= 1'b1;
      @(posedge clk);
      stop_exec <= 1'b0;
      nmi_req <= 1'b1;
      repeat (4) @(posedge clk);
      #1;
      chk("stopped", 3'b001, {cpu_clk_en, osc_enable, standby_hold});
      @(posedge clk);
      nmi_req <= 1'b0;
      global_irq_enable <= ie;
      mask_flags <= 16'hfffe;
      request_flags <= 16'h0001;
      @(posedge clk);
      request_flags <= 16'h0000;
      mask_flags <= 16'hffff;
      wait_run();
      chk("stop wait", settle_of(code), fit(n, settle_of(code)));
      chk("stop pulse", ie ? 2'b10 : 2'b01, wk);
    end
    // Halt: resume, vector, non-maskable, pending at entry
    for (int k = 0; k < 4; k++)
    begin
      @(posedge clk);
      mask_flags <= (k == 3) ? 16'hfffe : 16'hffff;
      request_flags <= 16'($urandom) | 16'h0001;
      global_irq_enable <= (k == 1);
      halt_exec <= 1'b1;
      @(posedge clk);
      halt_exec <= 1'b0;
      if (k < 3)
      begin
        repeat (3) @(posedge clk);
        #1;
        chk("halt", 3'b011, {cpu_clk_en, osc_enable, standby_hold});
        @(posedge clk);
        nmi_req <= (k == 2);
        mask_flags <= (k == 2) ? 16'hffff : 16'hfffe;
        @(posedge clk);
        nmi_req <= 1'b0;
      end
      wait_run();
      chk("halt wait", (k == 1 || k == 2) ? 8 : k / 3, n);
      chk("halt pulse", (k == 1 || k == 2) ? 2'b10 : 2'b01, wk);
    end
    // Acknowledge hold-off
    @(posedge clk);
    flag_instr_decode <= 1'b1;
    @(posedge clk);
    flag_instr_decode <= 1'b0;
    repeat ($urandom % 4 + 1) @(posedge clk);
    #1;
    chk("ack hold", 1, irq_ack_hold);
    @(posedge clk);
    flag_instr_done <= 1'b1;
    @(posedge clk);
    flag_instr_done <= 1'b0;
    @(posedge clk);
    #1;
    chk("ack free", 0, irq_ack_hold);
    // Decode and done in one cycle: the hold-off is set
    @(posedge clk);
    {flag_instr_decode, flag_instr_done} <= 2'b11;
    @(posedge clk);
    {flag_instr_decode, flag_instr_done} <= 2'b00;
    #1;
    chk("ack both", 1, irq_ack_hold);
    // Reset out of halt
    @(posedge clk);
    mask_flags <= 16'hffff;
    halt_exec <= 1'b1;
    @(posedge clk);
    halt_exec <= 1'b0;
    repeat (3) @(posedge clk);
    sys_rst <= 1'b1;
    repeat (2) @(posedge clk);
    sys_rst <= 1'b0;
    wait_run();
    chk("rst halt", C15, fit(n, C15));
    chk("rst pulse", 2'b00, wk);
    rreg(16'hfffa);
    chk("sel rst", 8'h04, d);
    stop_test();
  end
endmodule : test_standby_halt_stop_control
